// ### flash_array_model.sv
// flash array stand-in answering ordinary byte reads
`timescale 1ns/100ps
module flash_array_model (
   // clock
   input wire logic clk_sys_i,
   // read port
   input wire logic rd_i,
   input wire logic [15:0] rd_addr_i,
   output logic [7:0] rd_data_o
);
   logic [7:0] junk_r = 8'h00;
   // data stand only while the request stands, so the controller must take them
   // at the edge after it raised the request; junk otherwise exposes a late sample
   always @(posedge clk_sys_i) junk_r <= ~junk_r;
   assign rd_data_o = rd_i ? (rd_addr_i[7:0] ^ rd_addr_i[15:8] ^ 8'h5a) : junk_r;
endmodule

// ### self_program_flash_control.sv
// self-programming flash control: arming register, timed store/load, page buffer
// ==========================================
// How it works
// - lock byte read when pointer is 0x0001 and read armed within three cycles
// - read select and enable clear after read, or after four idle cycles
// - pointer 0x0000 with armed read returns fuse low byte
// - pointer 0x0003 with armed read returns fuse high byte
// - pointer 0x0002 with armed read returns extended fuse byte
// - programmed fuse and lock bits read as 0, unprogrammed as 1
// - with read not armed, load does an ordinary program memory byte read
// - reset aborts a write in progress: sequencer, timer and flash strobes clear
// - erase and write last between 3.7 ms and 4.5 ms
// - read-while-write busy bit 6 always reads zero
// - ready interrupt when enabled, global flag set, enable clear, no eeprom write
// - reserved bit 5 reads zero
// - writing read-enable bit while filling clears the temporary buffer
// - armed read selects lock or fuse byte by the whole pointer value, others give 0xff
// - armed page write then store programs page from buffer, cpu halted
// - page write bit clears on completion or four idle cycles
// - armed page erase then store erases page, cpu halted, self-clears
// - enable alone lets store put r1:r0 into buffer at pointer word
// - enable clears after store or four idle cycles, stays set while busy
// - only the listed command patterns start anything
// - eeprom write blocks flash programming and fuse or lock reads
// - buffer empties after page write and after reset
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module self_program_flash_control #(
   parameter int page_words = 32,
   parameter int page_addr_bits = 7,
   parameter int prog_cycles = spm_ctrl_pkg::prog_cyc
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // core instruction port
   input wire logic store_instr_i,
   input wire logic load_instr_i,
   input wire logic [15:0] prog_addr_pointer_i,
   input wire logic [15:0] store_data_i,
   input wire logic global_irq_en_i,
   input wire logic eeprom_write_busy_i,
   output logic [7:0] load_data_o,
   output logic load_valid_o,
   output logic cpu_halt_o,
   output logic spm_ready_irq_o,
   // flash array port
   output logic flash_rd_o,
   output logic [15:0] flash_rd_addr_o,
   input wire logic [7:0] flash_rd_data_i,
   output logic flash_erase_o,
   output logic flash_write_o,
   output logic [page_addr_bits-1:0] flash_page_o,
   output logic [15:0] flash_wdata_o,
   output logic [$clog2(page_words)-1:0] flash_widx_o,
   output logic flash_wvalid_o
);
   localparam int widx_bits = $clog2(page_words);
   localparam int word_lsb = 1;
   localparam int page_lsb = word_lsb + widx_bits;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_armed = 3'b001,
      st_erase = 3'b010,
      st_write = 3'b011,
      st_dump = 3'b100
   } seq_t;

   seq_t state_r;
   logic [7:0] ctrl_r;
   logic [2:0] arm_cnt_r;
   logic [31:0] prog_cnt_r;
   logic [widx_bits-1:0] dump_idx_r;
   logic [15:0] page_buf_r [page_words];
   logic [page_words-1:0] buf_valid_r;
   logic [7:0] fuse_low_r;
   logic [7:0] fuse_high_r;
   logic [7:0] fuse_ext_r;
   logic [7:0] lock_r;
   logic load_pend_r;
   logic eeprom_sync1_r;
   logic eeprom_sync2_r;
   logic wr_ctrl;
   logic cmd_ok;
   logic store_go;
   logic fl_armed;
   logic [4:0] cmd_lo;

   // a flag set by software is only taken as a command when the pattern is known
   function automatic logic cmd_known(input logic [4:0] c);
      cmd_known = (c == spm_ctrl_pkg::cmd_rww_re) || (c == spm_ctrl_pkg::cmd_fl_read) ||
                  (c == spm_ctrl_pkg::cmd_pg_write) || (c == spm_ctrl_pkg::cmd_pg_erase) ||
                  (c == spm_ctrl_pkg::cmd_buf_fill);
   endfunction

   // ==========================================
   // eeprom busy synchroniser
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eeprom_sync1_r <= 1'b0;
         eeprom_sync2_r <= 1'b0;
      end else begin
         eeprom_sync1_r <= eeprom_write_busy_i;
         eeprom_sync2_r <= eeprom_sync1_r;
      end
   end

   assign cmd_lo = reg_wdata_i[4:0];
   assign wr_ctrl = reg_wr_i && (reg_addr_i == spm_ctrl_pkg::ctrl_status_off);
   assign cmd_ok = wr_ctrl && cmd_known(cmd_lo) && !eeprom_sync2_r &&
                   (state_r == st_idle);
   assign fl_armed = (state_r == st_armed) && ctrl_r[spm_ctrl_pkg::bit_fl_sel] &&
                     (arm_cnt_r < 3'(spm_ctrl_pkg::load_window_cyc));
   assign store_go = (state_r == st_armed) && store_instr_i &&
                     !ctrl_r[spm_ctrl_pkg::bit_fl_sel];

   // ==========================================
   // sequencer and control/status register
   // the arm window counts from the cycle after the register write
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= st_idle;
         ctrl_r <= spm_ctrl_pkg::ctrl_status_rst;
         arm_cnt_r <= 3'h0;
         prog_cnt_r <= 32'h0;
         dump_idx_r <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r[spm_ctrl_pkg::bit_irq_en] <= reg_wdata_i[spm_ctrl_pkg::bit_irq_en];
         end
         case (state_r)
            st_idle: begin
               if (cmd_ok) begin
                  ctrl_r[4:0] <= cmd_lo;
                  arm_cnt_r <= 3'h0;
                  state_r <= (cmd_lo == spm_ctrl_pkg::cmd_rww_re) ? st_idle : st_armed;
                  if (cmd_lo == spm_ctrl_pkg::cmd_rww_re) begin
                     ctrl_r[4:0] <= 5'h00;
                  end
               end
            end
            st_armed: begin
               arm_cnt_r <= arm_cnt_r + 3'h1;
               if (fl_armed && load_instr_i) begin
                  ctrl_r[4:0] <= 5'h00;
                  state_r <= st_idle;
               end else if (store_go && ctrl_r[spm_ctrl_pkg::bit_pg_erase]) begin
                  prog_cnt_r <= 32'h0;
                  state_r <= st_erase;
               end else if (store_go && ctrl_r[spm_ctrl_pkg::bit_pg_write]) begin
                  prog_cnt_r <= 32'h0;
                  dump_idx_r <= '0;
                  state_r <= st_dump;
               end else if (store_go) begin
                  ctrl_r[4:0] <= 5'h00;
                  state_r <= st_idle;
               end else if (arm_cnt_r >= 3'(spm_ctrl_pkg::store_window_cyc - 1)) begin
                  ctrl_r[4:0] <= 5'h00;
                  state_r <= st_idle;
               end
            end
            st_dump: begin
               // page buffer streams to the array while the program timer already runs
               prog_cnt_r <= prog_cnt_r + 32'h1;
               dump_idx_r <= dump_idx_r + 1'b1;
               if (dump_idx_r == widx_bits'(page_words - 1)) begin
                  state_r <= st_write;
               end
            end
            st_erase, st_write: begin
               prog_cnt_r <= prog_cnt_r + 32'h1;
               if (prog_cnt_r >= 32'(prog_cycles - 1)) begin
                  ctrl_r[4:0] <= 5'h00;
                  state_r <= st_idle;
               end
            end
            default: state_r <= st_idle;
         endcase
      end
   end

   // ==========================================
   // temporary page buffer
   // the array itself lives outside; reset clears the operation timer and strobes
   // as well as the core-side state such as this buffer
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buf_valid_r <= '0;
      end else if (cmd_ok && (cmd_lo == spm_ctrl_pkg::cmd_rww_re)) begin
         buf_valid_r <= '0;
      end else if (state_r == st_write && prog_cnt_r >= 32'(prog_cycles - 1)) begin
         buf_valid_r <= '0;
      end else if (store_go && ctrl_r[4:0] == spm_ctrl_pkg::cmd_buf_fill) begin
         buf_valid_r[prog_addr_pointer_i[page_lsb-1:word_lsb]] <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (store_go && ctrl_r[4:0] == spm_ctrl_pkg::cmd_buf_fill) begin
         page_buf_r[prog_addr_pointer_i[page_lsb-1:word_lsb]] <= store_data_i;
      end
   end

   // ==========================================
   // fuse and lock storage, active-low: 1 means unprogrammed
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fuse_low_r <= spm_ctrl_pkg::fuse_rst;
         fuse_high_r <= spm_ctrl_pkg::fuse_rst;
         fuse_ext_r <= spm_ctrl_pkg::fuse_rst;
         lock_r <= spm_ctrl_pkg::fuse_rst;
      end else if (reg_wr_i) begin
         if (reg_addr_i == spm_ctrl_pkg::fuse_low_off) fuse_low_r <= reg_wdata_i;
         if (reg_addr_i == spm_ctrl_pkg::fuse_high_off) fuse_high_r <= reg_wdata_i;
         if (reg_addr_i == spm_ctrl_pkg::fuse_ext_off) fuse_ext_r <= reg_wdata_i;
         if (reg_addr_i == spm_ctrl_pkg::lock_bits_off) lock_r <= reg_wdata_i;
      end
   end

   // ==========================================
   // load path: fuse/lock answer or ordinary flash byte read
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         load_data_o <= 8'h00;
         load_valid_o <= 1'b0;
         load_pend_r <= 1'b0;
         flash_rd_o <= 1'b0;
         flash_rd_addr_o <= 16'h0000;
      end else begin
         load_valid_o <= 1'b0;
         flash_rd_o <= 1'b0;
         load_pend_r <= 1'b0;
         if (load_instr_i && fl_armed) begin
            load_valid_o <= 1'b1;
            case (prog_addr_pointer_i)
               spm_ctrl_pkg::ptr_lock: load_data_o <= lock_r;
               spm_ctrl_pkg::ptr_fuse_low: load_data_o <= fuse_low_r;
               spm_ctrl_pkg::ptr_fuse_high: load_data_o <= fuse_high_r;
               spm_ctrl_pkg::ptr_fuse_ext: load_data_o <= fuse_ext_r;
               default: load_data_o <= 8'hff;
            endcase
         end else if (load_instr_i) begin
            flash_rd_o <= 1'b1;
            flash_rd_addr_o <= prog_addr_pointer_i;
            load_pend_r <= 1'b1;
         end else if (load_pend_r) begin
            load_valid_o <= 1'b1;
            load_data_o <= flash_rd_data_i;
         end
      end
   end

   // ==========================================
   // flash array strobes and cpu halt
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flash_erase_o <= 1'b0;
         flash_write_o <= 1'b0;
         flash_page_o <= '0;
         flash_wdata_o <= 16'h0000;
         flash_widx_o <= '0;
         flash_wvalid_o <= 1'b0;
         cpu_halt_o <= 1'b0;
      end else begin
         flash_erase_o <= (state_r == st_erase) ||
                          (store_go && ctrl_r[spm_ctrl_pkg::bit_pg_erase]);
         flash_write_o <= (state_r == st_dump) || (state_r == st_write) ||
                          (store_go && ctrl_r[spm_ctrl_pkg::bit_pg_write]);
         cpu_halt_o <= (state_r == st_dump) || (state_r == st_erase) ||
                       (state_r == st_write) || (store_go && ctrl_r[2:1] != 2'b00);
         if (store_go) begin
            flash_page_o <= prog_addr_pointer_i[page_lsb +: page_addr_bits];
         end
         flash_wvalid_o <= (state_r == st_dump) && buf_valid_r[dump_idx_r];
         flash_widx_o <= dump_idx_r;
         flash_wdata_o <= buf_valid_r[dump_idx_r] ? page_buf_r[dump_idx_r] : 16'hffff;
      end
   end

   // ==========================================
   // ready interrupt and register read port
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spm_ready_irq_o <= 1'b0;
         reg_rdata_o <= 8'h00;
      end else begin
         spm_ready_irq_o <= ctrl_r[spm_ctrl_pkg::bit_irq_en] && global_irq_en_i &&
                            !ctrl_r[spm_ctrl_pkg::bit_spm_en] && !eeprom_sync2_r;
         reg_rdata_o <= 8'h00;
         if (reg_rd_i) begin
            case (reg_addr_i)
               spm_ctrl_pkg::ctrl_status_off: reg_rdata_o <= {ctrl_r[7], 1'b0, 1'b0,
                                                               ctrl_r[4:0]};
               spm_ctrl_pkg::fuse_low_off: reg_rdata_o <= fuse_low_r;
               spm_ctrl_pkg::fuse_high_off: reg_rdata_o <= fuse_high_r;
               spm_ctrl_pkg::fuse_ext_off: reg_rdata_o <= fuse_ext_r;
               spm_ctrl_pkg::lock_bits_off: reg_rdata_o <= lock_r;
               default: reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end
endmodule

// ### spm_ctrl_pkg.sv
// shared constants for the self-programming flash control block
package spm_ctrl_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] ctrl_status_off = 8'h37;
   localparam logic [7:0] fuse_low_off = 8'h40;
   localparam logic [7:0] fuse_high_off = 8'h41;
   localparam logic [7:0] fuse_ext_off = 8'h42;
   localparam logic [7:0] lock_bits_off = 8'h43;
   localparam logic [7:0] ctrl_status_rst = 8'h00;
   localparam logic [7:0] fuse_rst = 8'hff;
   // ==========================================
   // control/status bit positions
   localparam int bit_spm_en = 0;
   localparam int bit_pg_erase = 1;
   localparam int bit_pg_write = 2;
   localparam int bit_fl_sel = 3;
   localparam int bit_rww_re = 4;
   localparam int bit_rsvd = 5;
   localparam int bit_rww_busy = 6;
   localparam int bit_irq_en = 7;
   // ==========================================
   // command patterns in the lower five bits
   localparam logic [4:0] cmd_rww_re = 5'h11;
   localparam logic [4:0] cmd_fl_read = 5'h09;
   localparam logic [4:0] cmd_pg_write = 5'h05;
   localparam logic [4:0] cmd_pg_erase = 5'h03;
   localparam logic [4:0] cmd_buf_fill = 5'h01;
   // ==========================================
   // pointer values for fuse and lock read-back
   localparam logic [15:0] ptr_fuse_low = 16'h0000;
   localparam logic [15:0] ptr_lock = 16'h0001;
   localparam logic [15:0] ptr_fuse_ext = 16'h0002;
   localparam logic [15:0] ptr_fuse_high = 16'h0003;
   // ==========================================
   // timing
   localparam int load_window_cyc = 3;
   localparam int store_window_cyc = 4;
   localparam int clk_mhz = 25;
   localparam int prog_min_us = 3700;
   localparam int prog_max_us = 4500;
   localparam int prog_cyc = (prog_min_us * clk_mhz + 1);
endpackage

// ### spm_flash_checker_properties.sv
// assertion checker for the self-programming flash control ports
`timescale 1ns/100ps
module spm_flash_checker #(
   parameter int prog_cycles = 64
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // watched ports
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic load_instr_i,
   input wire logic load_valid_o,
   input wire logic global_irq_en_i,
   input wire logic eeprom_write_busy_i,
   input wire logic spm_ready_irq_o,
   input wire logic cpu_halt_o,
   input wire logic flash_rd_o,
   input wire logic flash_erase_o,
   input wire logic flash_write_o
);
   int halt_cnt;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // halt length, judged on the cycle it ends
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i)
         halt_cnt <= 0;
      else if (cpu_halt_o)
         halt_cnt <= halt_cnt + 1;
      else
         halt_cnt <= 0;
   end
   // ==========================================
   // properties
   sequence s_rd_ctrl;
      reg_rd_i && reg_addr_i == spm_ctrl_pkg::ctrl_status_off;
   endsequence
   sequence s_ord_answer;
      flash_rd_o ##1 load_valid_o;
   endsequence
   property p_rsvd;
      s_rd_ctrl |=> reg_rdata_o[5] == 1'b0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
   property p_rww_busy;
      s_rd_ctrl |=> reg_rdata_o[6] == 1'b0;
   endproperty
   a_rww_busy: assert property (p_rww_busy) else $error("busy bit read as one");
   property p_irq_global;
      !global_irq_en_i |=> !spm_ready_irq_o;
   endproperty
   a_irq_global: assert property (p_irq_global) else $error("irq without global flag");
   property p_irq_eeprom;
      eeprom_write_busy_i [*4] |-> !spm_ready_irq_o;
   endproperty
   a_irq_eeprom: assert property (p_irq_eeprom) else $error("irq in eeprom write");
   property p_irq_halt;
      cpu_halt_o |=> !spm_ready_irq_o;
   endproperty
   a_irq_halt: assert property (p_irq_halt) else $error("irq during operation");
   property p_halt_len;
      $fell(cpu_halt_o) |-> halt_cnt == prog_cycles + 1;
   endproperty
   a_halt_len: assert property (p_halt_len) else $error("operation length wrong");
   property p_halt_op;
      cpu_halt_o |-> flash_erase_o || flash_write_o;
   endproperty
   a_halt_op: assert property (p_halt_op) else $error("halt without operation");
   property p_load_ans;
      load_instr_i && !cpu_halt_o |-> ##[1:2] load_valid_o;
   endproperty
   a_load_ans: assert property (p_load_ans) else $error("load not answered");
   property p_ord_read;
      flash_rd_o |-> s_ord_answer;
   endproperty
   a_ord_read: assert property (p_ord_read) else $error("byte read not answered");
   property p_erase_halt;
      $rose(flash_erase_o) |-> cpu_halt_o && !flash_write_o;
   endproperty
   a_erase_halt: assert property (p_erase_halt) else $error("erase without halt");
endmodule
bind self_program_flash_control spm_flash_checker #(.prog_cycles(prog_cycles)) chk_u (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .load_instr_i(load_instr_i), .load_valid_o(load_valid_o),
   .global_irq_en_i(global_irq_en_i), .eeprom_write_busy_i(eeprom_write_busy_i),
   .spm_ready_irq_o(spm_ready_irq_o), .cpu_halt_o(cpu_halt_o), .flash_rd_o(flash_rd_o),
   .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o)
);

// ### tb_self_program_flash_control.sv
// self-checking bench for the self-programming flash control block
`timescale 1ns/100ps
module tb_self_program_flash_control;
   localparam int prog_n = 64;
   localparam logic [7:0] ctl = spm_ctrl_pkg::ctrl_status_off;
   localparam logic [7:0] bad [5] = '{8'h1f, 8'h07, 8'h0b, 8'h02, 8'he0};
   localparam int ptr_of [4] = '{0, 3, 2, 1};
   localparam int word_of [3] = '{0, 5, 31};
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic store_i = 1'b0;
   logic load_i = 1'b0;
   logic [15:0] z_ptr = 16'h0000;
   logic [15:0] st_data = 16'h0000;
   logic glob = 1'b0;
   logic ee_busy = 1'b0;
   logic [7:0] rdata, ld_data, fl_data;
   logic ld_valid, halt, irq, fl_rd, fl_erase, fl_write, wvalid;
   logic [15:0] fl_addr, wdata;
   logic [6:0] page;
   logic [4:0] widx;
   logic [7:0] fuse [4];
   logic [31:0] seed = 32'h13;
   int miscompares = 0;
   int total_checks = 0;
   int got_q[$];
   int exp_q[$];
   always #20 clk_sys_i = ~clk_sys_i;
   self_program_flash_control #(.prog_cycles(prog_n)) dut_u (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .store_instr_i(store_i),
      .load_instr_i(load_i), .prog_addr_pointer_i(z_ptr), .store_data_i(st_data),
      .global_irq_en_i(glob), .eeprom_write_busy_i(ee_busy), .load_data_o(ld_data),
      .load_valid_o(ld_valid), .cpu_halt_o(halt), .spm_ready_irq_o(irq), .flash_rd_o(fl_rd),
      .flash_rd_addr_o(fl_addr), .flash_rd_data_i(fl_data), .flash_erase_o(fl_erase),
      .flash_write_o(fl_write), .flash_page_o(page), .flash_wdata_o(wdata),
      .flash_widx_o(widx), .flash_wvalid_o(wvalid)
   );
   flash_array_model mem_u (.clk_sys_i(clk_sys_i), .rd_i(fl_rd), .rd_addr_i(fl_addr),
      .rd_data_o(fl_data));
   always @(posedge clk_sys_i) if (wvalid === 1'b1) got_q.push_back({widx, wdata});
   // ==========================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] fl_byte(logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic instr(input bit is_load, input logic [15:0] p, input logic [15:0] d);
      @(posedge clk_sys_i);
      z_ptr <= p;
      st_data <= d;
      if (is_load) load_i <= 1'b1;
      else store_i <= 1'b1;
      @(posedge clk_sys_i);
      load_i <= 1'b0;
      store_i <= 1'b0;
      #1;
   endtask
   task automatic ld(input logic [15:0] p, input logic [7:0] exp);
      instr(1'b1, p, 16'h0000);
      for (int i = 0; i < 3 && ld_valid !== 1'b1; i++) @(posedge clk_sys_i) #1;
      chk(ld_valid, 1'b1);
      chk(ld_data, exp);
   endtask
   task automatic page_op(input logic [7:0] cmd, input logic [15:0] p);
      got_q = {};
      wr(ctl, cmd);
      instr(1'b0, p, 16'hffff);
      chk(halt, 1'b1);
      chk(page, p[12:6]);
      rd(ctl, cmd);
      for (int i = 0; i < prog_n + 8 && halt === 1'b1; i++) @(posedge clk_sys_i) #1;
      rd(ctl, 8'h00);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      logic [15:0] d;
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(ctl, spm_ctrl_pkg::ctrl_status_rst);
      rd(spm_ctrl_pkg::fuse_low_off, spm_ctrl_pkg::fuse_rst);
      rd(8'h7f, 8'h00);
      foreach (bad[i]) begin
         wr(ctl, bad[i]);
         rd(ctl, bad[i] & 8'h80);
      end
      wr(ctl, 8'h00);
      $display("test register map finished");
      foreach (fuse[i]) begin
         fuse[i] = 8'(rnd());
         wr(spm_ctrl_pkg::fuse_low_off + 8'(i), fuse[i]);
         wr(ctl, 8'h09);
         ld(16'(ptr_of[i]), fuse[i]);
         rd(ctl, 8'h00);
      end
      wr(ctl, 8'h09);
      repeat (4) @(posedge clk_sys_i);
      ld(16'h0001, fl_byte(16'h0001));
      $display("test fuse read finished");
      wr(ctl, 8'h01);
      repeat (5) @(posedge clk_sys_i);
      rd(ctl, 8'h00);
      instr(1'b0, 16'h014f, 16'h1234);
      foreach (word_of[k]) begin
         d = 16'(rnd());
         exp_q.push_back({word_of[k][4:0], d});
         wr(ctl, 8'h01);
         instr(1'b0, {3'h0, 7'h05, word_of[k][4:0], 1'b1}, d);
      end
      page_op(8'h05, 16'h0140);
      chk(got_q.size(), exp_q.size());
      foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
      wr(ctl, 8'h01);
      instr(1'b0, 16'h0144, 16'h5555);
      wr(ctl, 8'h11);
      page_op(8'h05, 16'h0140);
      chk(got_q.size(), 0);
      page_op(8'h03, 16'h0380);
      $display("test page operations finished");
      wr(ctl, 8'h80);
      glob <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1 chk(irq, 1'b1);
      @(posedge clk_sys_i);
      ee_busy <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      #1 chk(irq, 1'b0);
      wr(ctl, 8'h89);
      ld(16'h0001, fl_byte(16'h0001));
      rd(ctl, 8'h80);
      @(posedge clk_sys_i);
      ee_busy <= 1'b0;
      glob <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #1 chk(irq, 1'b0);
      $display("test interrupt and eeprom finished");
      finish_test();
   end
   initial begin
      #(40 * 20000);
      miscompares++;
      finish_test();
   end
endmodule
